// ---- lcdp_i2c_port.sv ----
// two-wire slave port with display ram, pointer and settings of the lcd controller
`timescale 1ns/1ps
`include "lcdp_regs.svh"

module lcdp_i2c_port
  import lcdp_pkg::*;
#(
  parameter int ADDR_W = `LCDP_ADDR_BITS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic bus_busy,
  output logic [3:0] lcd_drive_voltage_trim_code,
  output logic lcd_drive_voltage_adj_en,
  output logic seg_lcd_drive_voltage_pin_sel,
  output logic duty_eighth,
  output logic bias_quarter,
  output logic osc_en,
  output logic display_on,
  output logic frame_160hz,
  output logic [1:0] blink_mode
);
  localparam int DEPTH = 1 << ADDR_W;
  localparam logic [7:0] DRIVE_RST = `LCDP_DRIVE_RESET;
  localparam logic [7:0] SYSTEM_RST = `LCDP_SYSTEM_RESET;
  localparam logic [7:0] FRAME_RST = `LCDP_FRAME_RESET;
  localparam logic [7:0] BLINK_RST = `LCDP_BLINK_RESET;
  localparam logic [7:0] IVA_RST = `LCDP_IVA_RESET;
  localparam lcdp_cfg_type CFG_RST = '{
    iva_de: IVA_RST[`LCDP_IVA_DE_BIT],
    iva_ve: IVA_RST[`LCDP_IVA_VE_BIT],
    trim: IVA_RST[`LCDP_TRIM_LSB +: 4],
    duty: DRIVE_RST[`LCDP_DUTY_BIT],
    bias: DRIVE_RST[`LCDP_BIAS_BIT],
    sys_s: SYSTEM_RST[`LCDP_SYS_S_BIT],
    sys_e: SYSTEM_RST[`LCDP_SYS_E_BIT],
    frame: FRAME_RST[`LCDP_FRAME_BIT],
    blink: BLINK_RST[`LCDP_BLINK_LSB +: 2]
  };
  // link-domain reset, taken from the core reset
  logic [1:0] lrst_sync_reg;
  logic link_rst;
  always_ff @(posedge link_clk) begin
    lrst_sync_reg <= {lrst_sync_reg[0], rst};
  end
  assign link_rst = lrst_sync_reg[1];
  // pin synchronisers; third stage only for edge detection
  logic scl_meta_reg, scl_sync_reg, scl_prev_reg;
  logic sda_meta_reg, sda_sync_reg, sda_prev_reg;
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      scl_meta_reg <= 1'b1;
      scl_sync_reg <= 1'b1;
      scl_prev_reg <= 1'b1;
      sda_meta_reg <= 1'b1;
      sda_sync_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_meta_reg <= scl_i;
      scl_sync_reg <= scl_meta_reg;
      scl_prev_reg <= scl_sync_reg;
      sda_meta_reg <= sda_i;
      sda_sync_reg <= sda_meta_reg;
      sda_prev_reg <= sda_sync_reg;
    end
  end

  logic scl_rise, scl_fall, start_det, stop_det;
  assign scl_rise = scl_sync_reg & ~scl_prev_reg;
  assign scl_fall = ~scl_sync_reg & scl_prev_reg;
  assign start_det = scl_sync_reg & scl_prev_reg & sda_prev_reg & ~sda_sync_reg;
  assign stop_det = scl_sync_reg & scl_prev_reg & ~sda_prev_reg & sda_sync_reg;
  lcdp_state_type state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] tx_shift_reg;
  logic [7:0] cmd_reg;
  logic got_byte_reg;
  logic in_ack_reg;
  logic mack_reg;
  logic sda_oe_reg;
  logic sda_oe_next;
  logic busy_reg;
  logic [ADDR_W-1:0] ptr_reg;
  logic [7:0] ram [DEPTH];
  lcdp_cfg_type cfg_reg;
  logic cfg_tgl_reg;
  logic [7:0] ram_rd;
  logic addr_hit, byte_end, ack_end, wr_adv, rd_adv, ptr_adv;
  logic [ADDR_W-1:0] ptr_last, ptr_step;
  assign ram_rd = ram[ptr_reg];
  assign addr_hit = (shift_reg[7:1] == `LCDP_SLAVE_ADDR);
  assign byte_end = scl_fall & got_byte_reg;
  assign ack_end = scl_fall & in_ack_reg & ~got_byte_reg;
  assign wr_adv = ack_end & (state_reg == ST_WDATA);
  assign rd_adv = scl_rise & (state_reg == ST_TX) & ~in_ack_reg
                  & (bit_cnt_reg == `LCDP_BIT_ACK) & ~sda_sync_reg;
  assign ptr_adv = wr_adv | rd_adv;
  assign ptr_last = cfg_reg.duty ? ADDR_W'(`LCDP_LAST_EIGHTH) : ADDR_W'(`LCDP_LAST_QUARTER);
  assign ptr_step = (ptr_reg == ptr_last) ? '0 : ptr_reg + ADDR_W'(1);

  // byte sequencing; a start anywhere restarts address reception
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      tx_shift_reg <= 8'h00;
      cmd_reg <= 8'h00;
      got_byte_reg <= 1'b0;
      in_ack_reg <= 1'b0;
      mack_reg <= 1'b0;
    end else if (start_det) begin
      state_reg <= ST_ADDR;
      bit_cnt_reg <= 4'h0;
      got_byte_reg <= 1'b0;
      in_ack_reg <= 1'b0;
    end else if (stop_det) begin
      state_reg <= ST_IDLE;
      got_byte_reg <= 1'b0;
      in_ack_reg <= 1'b0;
    end else if (state_reg != ST_IDLE) begin
      if (scl_rise && !in_ack_reg && state_reg != ST_TX) begin
        shift_reg <= {shift_reg[6:0], sda_sync_reg};
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
        if (bit_cnt_reg == `LCDP_BIT_LAST) begin
          got_byte_reg <= 1'b1;
        end
      end
      if (scl_rise && state_reg == ST_TX && !in_ack_reg && bit_cnt_reg == `LCDP_BIT_ACK) begin
        mack_reg <= ~sda_sync_reg;
      end
      if (byte_end) begin
        got_byte_reg <= 1'b0;
        in_ack_reg <= 1'b1;
        bit_cnt_reg <= 4'h0;
        unique case (state_reg)
          ST_ADDR: begin
            if (addr_hit) begin
              state_reg <= shift_reg[0] ? ST_TX : ST_CMD;
            end else begin
              state_reg <= ST_IDLE;
              in_ack_reg <= 1'b0;
            end
          end
          ST_CMD: begin
            cmd_reg <= shift_reg;
            state_reg <= (shift_reg == `LCDP_CMD_DATA) ? ST_PTR : ST_ARG;
          end
          ST_PTR: state_reg <= ST_WDATA;
          ST_WDATA: state_reg <= ST_WDATA;
          ST_ARG: state_reg <= ST_ARG;
          ST_IDLE, ST_TX: state_reg <= state_reg;
        endcase
      end else if (ack_end) begin
        in_ack_reg <= 1'b0;
        bit_cnt_reg <= 4'h0;
        if (state_reg == ST_TX) begin
          tx_shift_reg <= ram_rd;
        end
      end else if (scl_fall && state_reg == ST_TX) begin
        if (bit_cnt_reg == `LCDP_BIT_ACK) begin
          if (mack_reg) begin
            tx_shift_reg <= ram_rd;
            bit_cnt_reg <= 4'h0;
          end else begin
            state_reg <= ST_IDLE;
          end
        end else begin
          tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end
      end
    end
  end

  // open-drain drive; changes fall on a clock fall, except the release forced by a start or stop
  always_comb begin
    sda_oe_next = sda_oe_reg;
    if (start_det || stop_det) begin
      sda_oe_next = 1'b0;
    end else if (state_reg != ST_IDLE && scl_fall) begin
      if (got_byte_reg) begin
        sda_oe_next = (state_reg == ST_ADDR) ? addr_hit : 1'b1;
      end else if (in_ack_reg) begin
        sda_oe_next = (state_reg == ST_TX) ? ~ram_rd[7] : 1'b0;
      end else if (state_reg == ST_TX) begin
        if (bit_cnt_reg == `LCDP_BIT_ACK) begin
          sda_oe_next = mack_reg ? ~ram_rd[7] : 1'b0;
        end else if (bit_cnt_reg == `LCDP_BIT_LAST) begin
          sda_oe_next = 1'b0;
        end else begin
          sda_oe_next = ~tx_shift_reg[6];
        end
      end
    end
  end

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      sda_oe_reg <= 1'b0;
      sda_o <= 1'b0;
    end else begin
      sda_oe_reg <= sda_oe_next;
      sda_o <= 1'b0;
    end
  end
  assign sda_oe = sda_oe_reg;
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      busy_reg <= 1'b0;
    end else if (start_det) begin
      busy_reg <= 1'b1;
    end else if (stop_det) begin
      busy_reg <= 1'b0;
    end
  end
  assign bus_busy = busy_reg;
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      ptr_reg <= ADDR_W'(`LCDP_PTR_RESET);
    end else if (byte_end && state_reg == ST_PTR) begin
      ptr_reg <= shift_reg[ADDR_W-1:0];
    end else if (ptr_adv) begin
      ptr_reg <= ptr_step;
    end
  end

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        ram[i] <= 8'h00;
      end
    end else if (byte_end && state_reg == ST_WDATA) begin
      ram[ptr_reg] <= shift_reg;
    end
  end

  // settings; each accepted setting byte toggles the crossing flag
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      cfg_reg <= CFG_RST;
      cfg_tgl_reg <= 1'b0;
    end else if (byte_end && state_reg == ST_ARG) begin
      unique case (cmd_reg)
        `LCDP_CMD_DRIVE: begin
          cfg_reg.duty <= shift_reg[`LCDP_DUTY_BIT];
          cfg_reg.bias <= shift_reg[`LCDP_BIAS_BIT];
          cfg_tgl_reg <= ~cfg_tgl_reg;
        end
        `LCDP_CMD_SYSTEM: begin
          cfg_reg.sys_s <= shift_reg[`LCDP_SYS_S_BIT];
          cfg_reg.sys_e <= shift_reg[`LCDP_SYS_E_BIT];
          cfg_tgl_reg <= ~cfg_tgl_reg;
        end
        `LCDP_CMD_FRAME: begin
          cfg_reg.frame <= shift_reg[`LCDP_FRAME_BIT];
          cfg_tgl_reg <= ~cfg_tgl_reg;
        end
        `LCDP_CMD_BLINK: begin
          cfg_reg.blink <= shift_reg[`LCDP_BLINK_LSB +: 2];
          cfg_tgl_reg <= ~cfg_tgl_reg;
        end
        `LCDP_CMD_IVA: begin
          cfg_reg.iva_de <= shift_reg[`LCDP_IVA_DE_BIT];
          cfg_reg.iva_ve <= shift_reg[`LCDP_IVA_VE_BIT];
          cfg_reg.trim <= shift_reg[`LCDP_TRIM_LSB +: 4];
          cfg_tgl_reg <= ~cfg_tgl_reg;
        end
        default: cfg_reg <= cfg_reg;
      endcase
    end
  end

  // core side: settings word is stable for many scl periods, so a synced toggle suffices
  logic tgl_meta_reg, tgl_sync_reg, tgl_prev_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      tgl_meta_reg <= 1'b0;
      tgl_sync_reg <= 1'b0;
      tgl_prev_reg <= 1'b0;
    end else begin
      tgl_meta_reg <= cfg_tgl_reg;
      tgl_sync_reg <= tgl_meta_reg;
      tgl_prev_reg <= tgl_sync_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      lcd_drive_voltage_trim_code <= CFG_RST.trim;
      lcd_drive_voltage_adj_en <= CFG_RST.iva_ve;
      seg_lcd_drive_voltage_pin_sel <= CFG_RST.iva_de;
      duty_eighth <= CFG_RST.duty;
      bias_quarter <= CFG_RST.bias;
      osc_en <= CFG_RST.sys_s;
      display_on <= 1'b0;
      frame_160hz <= CFG_RST.frame;
      blink_mode <= CFG_RST.blink;
    end else if (tgl_sync_reg != tgl_prev_reg) begin
      lcd_drive_voltage_trim_code <= cfg_reg.trim;
      lcd_drive_voltage_adj_en <= cfg_reg.iva_ve;
      seg_lcd_drive_voltage_pin_sel <= cfg_reg.iva_de;
      duty_eighth <= cfg_reg.duty;
      bias_quarter <= cfg_reg.bias;
      osc_en <= cfg_reg.sys_s;
      display_on <= cfg_reg.sys_s & cfg_reg.sys_e;
      frame_160hz <= cfg_reg.frame;
      blink_mode <= cfg_reg.blink;
    end
  end

  default clocking cb @(posedge link_clk); endclocking
  default disable iff (link_rst);
  sequence s_addr_byte_end;
    byte_end && state_reg == ST_ADDR;
  endsequence
  sequence s_read_ack_rise;
    scl_rise && state_reg == ST_TX && !in_ack_reg && bit_cnt_reg == `LCDP_BIT_ACK;
  endsequence
  chk_sda_hold_high: assert property (
    scl_sync_reg && scl_prev_reg && !start_det && !stop_det |=> $stable(sda_oe_reg))
    else $error("data drive changed while clock high");
  chk_start_addr: assert property (
    start_det |=> state_reg == ST_ADDR && bit_cnt_reg == 4'h0 && !sda_oe_reg)
    else $error("start did not restart address reception");
  chk_stop_idle: assert property (
    stop_det |=> state_reg == ST_IDLE && !busy_reg && !sda_oe_reg)
    else $error("stop did not end the transfer");
  chk_busy_span: assert property (
    start_det || (busy_reg && !stop_det) |=> busy_reg)
    else $error("bus busy lost before stop");
  chk_addr_match: assert property (
    s_addr_byte_end and (addr_hit) |=> sda_oe_reg && state_reg != ST_IDLE)
    else $error("matching address not acknowledged");
  chk_addr_miss: assert property (
    s_addr_byte_end and (!addr_hit) |=> !sda_oe_reg && state_reg == ST_IDLE)
    else $error("foreign address not ignored");
  chk_rx_ack: assert property (
    byte_end && state_reg inside {ST_CMD, ST_PTR, ST_WDATA, ST_ARG} |=> sda_oe_reg)
    else $error("received byte not acknowledged");
  chk_ptr_step: assert property (
    ptr_adv && ptr_reg != ptr_last |=> ptr_reg == $past(ptr_reg) + ADDR_W'(1))
    else $error("pointer did not step by one");
  chk_ptr_wrap: assert property (
    ptr_adv && ptr_reg == ptr_last |=> ptr_reg == '0)
    else $error("pointer did not wrap to zero");
  chk_ptr_reset: assert property (
    disable iff (1'b0) link_rst |=> ptr_reg == '0)
    else $error("pointer not at zero after reset");
  chk_read_nack: assert property (
    s_read_ack_rise and (sda_sync_reg) |=> $stable(ptr_reg))
    else $error("pointer moved on not-acknowledge");
  chk_undef_cmd: assert property (
    byte_end && state_reg == ST_ARG && !(cmd_reg inside {`LCDP_CMD_DRIVE, `LCDP_CMD_SYSTEM,
      `LCDP_CMD_FRAME, `LCDP_CMD_BLINK, `LCDP_CMD_IVA})
      |=> $stable(cfg_reg) && $stable(cfg_tgl_reg))
    else $error("undefined command changed a setting");
  chk_ram_store: assert property (
    byte_end && state_reg == ST_WDATA |=> ram[$past(ptr_reg)] == $past(shift_reg))
    else $error("data byte not stored at pointer");
endmodule : lcdp_i2c_port

// ---- lcdp_regs.svh ----
// constants for the two-wire lcd ram port: address, commands, fields, reset values
`ifndef LCDP_REGS_SVH
`define LCDP_REGS_SVH

`define LCDP_SLAVE_ADDR 7'h38
`define LCDP_ADDR_BITS 4

`define LCDP_CMD_DATA 8'h80
`define LCDP_CMD_DRIVE 8'h82
`define LCDP_CMD_SYSTEM 8'h84
`define LCDP_CMD_FRAME 8'h86
`define LCDP_CMD_BLINK 8'h88
`define LCDP_CMD_IVA 8'h8a

`define LCDP_LAST_QUARTER 4'h9
`define LCDP_LAST_EIGHTH 4'hf
`define LCDP_PTR_RESET 4'h0

`define LCDP_DUTY_BIT 1
`define LCDP_BIAS_BIT 0
`define LCDP_SYS_S_BIT 1
`define LCDP_SYS_E_BIT 0
`define LCDP_FRAME_BIT 0
`define LCDP_BLINK_LSB 0
`define LCDP_IVA_DE_BIT 5
`define LCDP_IVA_VE_BIT 4
`define LCDP_TRIM_LSB 0

`define LCDP_DRIVE_RESET 8'h00
`define LCDP_SYSTEM_RESET 8'h00
`define LCDP_FRAME_RESET 8'h00
`define LCDP_BLINK_RESET 8'h00
`define LCDP_IVA_RESET 8'h30

`define LCDP_BIT_LAST 4'h7
`define LCDP_BIT_ACK 4'h8

`endif

// ---- lcdp_pkg.sv ----
// types shared by the two-wire lcd ram port
package lcdp_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_CMD,
    ST_PTR,
    ST_WDATA,
    ST_ARG,
    ST_TX
  } lcdp_state_type;

  typedef struct packed {
    logic iva_de;
    logic iva_ve;
    logic [3:0] trim;
    logic duty;
    logic bias;
    logic sys_s;
    logic sys_e;
    logic frame;
    logic [1:0] blink;
  } lcdp_cfg_type;

endpackage : lcdp_pkg

// ---- lcdp_host_model.sv ----
// bus master model that clocks the two-wire lcd ram port
`timescale 1ns/1ps
module lcdp_host_model #(
  parameter int Q = 5
) (
  input wire logic link_clk,
  input wire logic sda,
  output logic scl,
  output logic sda_pull
);
  // idle bus: both lines high; transfers begin from here or from a repeated start
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge link_clk);
  endtask : tick

  // data moves only while scl is low; high phase sampled twice
  task automatic bit_cycle(input logic b, output logic s);
    logic s_a;
    sda_pull <= ~b;
    tick(Q);
    scl <= 1'b1;
    tick(Q);
    s_a = sda;
    tick(Q);
    // a line that moves during the high phase reads as unknown
    s = (s_a === sda) ? s_a : 1'bx;
    scl <= 1'b0;
    tick(Q);
  endtask : bit_cycle

  // also serves as repeated start from a low clock
  task automatic start_cond();
    sda_pull <= 1'b0;
    tick(Q);
    scl <= 1'b1;
    tick(Q);
    sda_pull <= 1'b1;
    tick(Q);
    scl <= 1'b0;
    tick(Q);
  endtask : start_cond

  task automatic stop_cond();
    sda_pull <= 1'b1;
    tick(Q);
    scl <= 1'b1;
    tick(Q);
    sda_pull <= 1'b0;
    tick(Q);
  endtask : stop_cond

  // msb first, ninth clock released for the device ack
  task automatic write_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_cycle(d[i], s);
    bit_cycle(1'b1, ack);
  endtask : write_byte

  // last byte of a read is marked by leaving the line high
  task automatic read_byte(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_cycle(1'b1, d[i]);
    bit_cycle(nack, s);
  endtask : read_byte
endmodule : lcdp_host_model

// ---- test_i2c_lcd_ram_port.sv ----
// self-checking bench for the two-wire lcd ram port
`timescale 1ns/1ps
module test_i2c_lcd_ram_port;
  import lcdp_pkg::*;
  logic clk, link_clk, rst, scl, sda_pull, sda_wire, sda_o, sda_oe, bus_busy;
  logic [3:0] lcd_drive_voltage_trim_code;
  logic lcd_drive_voltage_adj_en, seg_lcd_drive_voltage_pin_sel, duty_eighth, bias_quarter, osc_en, display_on;
  logic frame_160hz;
  logic [1:0] blink_mode;
  int miscompares, compares;
  logic [31:0] seed, tmp;
  lcdp_cfg_type ec;
  logic [7:0] ram_exp [16];
  logic [7:0] cmds [5] = '{8'h82, 8'h84, 8'h86, 8'h88, 8'h8a};
  logic [7:0] rd;
  logic [3:0] ptr;
  logic ack;

  // open drain with pull-up
  assign sda_wire = (sda_oe || sda_pull) ? 1'b0 : 1'b1;

  lcdp_i2c_port lcdp_i2c_port_inst (.clk(clk), .rst(rst), .link_clk(link_clk), .scl_i(scl),
    .sda_i(sda_wire), .sda_o(sda_o), .sda_oe(sda_oe), .bus_busy(bus_busy),
    .lcd_drive_voltage_trim_code(lcd_drive_voltage_trim_code), .lcd_drive_voltage_adj_en(lcd_drive_voltage_adj_en),
    .seg_lcd_drive_voltage_pin_sel(seg_lcd_drive_voltage_pin_sel), .duty_eighth(duty_eighth),
    .bias_quarter(bias_quarter), .osc_en(osc_en), .display_on(display_on),
    .frame_160hz(frame_160hz), .blink_mode(blink_mode));
  lcdp_host_model lcdp_host_model_inst (.link_clk(link_clk), .sda(sda_wire), .scl(scl),
    .sda_pull(sda_pull));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #16 link_clk = ~link_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic logic [3:0] nxt(input logic [3:0] p);
    return (!ec.duty && p == 4'h9) ? 4'h0 : p + 4'h1;
  endfunction : nxt

  // unknown command codes fall through untouched
  function automatic lcdp_cfg_type apply(input lcdp_cfg_type c, input logic [7:0] cmd,
                                         input logic [7:0] arg);
    case (cmd)
      8'h82: {c.duty, c.bias} = arg[1:0];
      8'h84: {c.sys_s, c.sys_e} = arg[1:0];
      8'h86: c.frame = arg[0];
      8'h88: c.blink = arg[1:0];
      8'h8a: {c.iva_de, c.iva_ve, c.trim} = arg[5:0];
      default: c = c;
    endcase
    return c;
  endfunction : apply

  // settings cross into the core domain a few cycles after the byte
  task automatic chk_cfg();
    repeat (10) @(posedge clk);
    check(32'({seg_lcd_drive_voltage_pin_sel, lcd_drive_voltage_adj_en, lcd_drive_voltage_trim_code, duty_eighth, bias_quarter, osc_en,
      display_on, frame_160hz, blink_mode}), 32'({ec.iva_de, ec.iva_ve, ec.trim, ec.duty,
      ec.bias, ec.sys_s, ec.sys_s & ec.sys_e, ec.frame, ec.blink}));
  endtask : chk_cfg

  task automatic send(input logic [7:0] d, input logic exp_ack);
    lcdp_host_model_inst.write_byte(d, ack);
    check(32'(ack), 32'(exp_ack));
  endtask : send

  task automatic begin_xfer();
    lcdp_host_model_inst.start_cond();
    check(32'(bus_busy), 32'h1);
  endtask : begin_xfer

  task automatic end_xfer();
    lcdp_host_model_inst.stop_cond();
    repeat (3) @(posedge link_clk);
    check(32'(bus_busy), 32'h0);
  endtask : end_xfer

  task automatic cfg_write(input logic [7:0] cmd, input logic [7:0] arg);
    begin_xfer();
    send(8'h70, 1'b0);
    send(cmd, 1'b0);
    send(arg, 1'b0);
    end_xfer();
    ec = apply(ec, cmd, arg);
    chk_cfg();
  endtask : cfg_write

  task automatic set_ptr(input logic [3:0] p);
    begin_xfer();
    send(8'h70, 1'b0);
    send(8'h80, 1'b0);
    send({4'h0, p}, 1'b0);
    ptr = p;
  endtask : set_ptr

  task automatic ram_write(input logic [3:0] p, input int n);
    logic [31:0] r;
    set_ptr(p);
    for (int i = 0; i < n; i++) begin
      r = rnd();
      send(r[7:0], 1'b0);
      ram_exp[ptr] = r[7:0];
      ptr = nxt(ptr);
    end
    end_xfer();
  endtask : ram_write

  task automatic ram_read(input logic [3:0] p, input int n);
    set_ptr(p);
    begin_xfer();
    send(8'h71, 1'b0);
    for (int i = 0; i < n; i++) begin
      lcdp_host_model_inst.read_byte(i == n - 1, rd);
      check(32'(rd), 32'(ram_exp[ptr]));
      if (i < n - 1) ptr = nxt(ptr);
    end
    // a refused byte leaves the pointer where it was
    begin_xfer();
    send(8'h71, 1'b0);
    lcdp_host_model_inst.read_byte(1'b1, rd);
    check(32'(rd), 32'(ram_exp[ptr]));
    end_xfer();
  endtask : ram_read

  always @(posedge link_clk) begin
    if (sda_oe === 1'b1) check(32'(sda_o), 32'h0);
  end

  initial begin
    #5_000_000;
    miscompares++;
    stop_test();
  end

  initial begin
    seed = 32'd64424;
    miscompares = 0;
    compares = 0;
    rst = 1'b1;
    ec = '0;
    ec.iva_de = 1'b1;
    ec.iva_ve = 1'b1;
    foreach (ram_exp[i]) ram_exp[i] = 8'h00;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk_cfg();
    check(32'(bus_busy), 32'h0);
    repeat (20000) @(posedge clk); // quiet first millisecond
    begin_xfer();
    send(8'h72, 1'b1);
    send(8'h8a, 1'b1);
    send(8'h0f, 1'b1);
    end_xfer();
    chk_cfg();
    cfg_write(8'h90, 8'hff);
    cfg_write(8'h81, 8'h3f);
    for (int i = 0; i < 15; i++) begin
      tmp = rnd();
      cfg_write(cmds[i % 5], tmp[15:8]);
    end
    cfg_write(8'h82, 8'h00);
    ram_write(4'h3, 1);
    ram_write(4'h8, 4);
    ram_read(4'h8, 4);
    ram_read(4'h3, 1);
    cfg_write(8'h82, 8'h02);
    ram_write(4'he, 3);
    ram_read(4'he, 3);
    tmp = rnd();
    ram_write(tmp[3:0], 16);
    ram_read(tmp[7:4], 17);
    stop_test();
  end
endmodule : test_i2c_lcd_ram_port
